// File: rtf_defines.svh
// Register map, field layout and reset constants of the time and date field block.
// Assumes inclusion by bare name; it holds definitions only.
`ifndef RTF_DEFINES_SVH
`define RTF_DEFINES_SVH
`define RTF_OFF_MIN 12'h004
`define RTF_OFF_HOUR 12'h008
`define RTF_OFF_WDAY 12'h00c
`define RTF_OFF_MDAY 12'h010
`define RTF_OFF_MONTH 12'h014
`define RTF_OFF_BANK 12'h01c
`define RTF_MIN_W 7
`define RTF_HOUR_W 6
`define RTF_WDAY_W 3
`define RTF_MDAY_W 6
`define RTF_PM_BIT 5
`define RTF_BANK_RST 1'h0
`endif

// File: rtf_monitor.sv
// Port checker for the time and date field block.
// Assumes a bind onto rtf_time_date_fields; it sees only that module's ports.
`timescale 1ns/1ns
module rtf_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [6:0] clk_minute,
  input wire logic [5:0] clk_hour,
  input wire logic hour_pm,
  input wire logic twelve_24_select,
  input wire logic bank_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Only the low byte lane writes, so a write with pstrb[0] low must be ignored.
  logic wr;
  logic rd;
  assign wr = psel & penable & pwrite & pstrb[0];
  assign rd = psel & penable & ~pwrite;
  clk_min_a: assert property (wr && paddr == 12'h004 && !bank_sel
    |=> clk_minute == $past(pwdata[6:0])) else $error("clock minute not stored");
  bank_keep_a: assert property (wr && paddr == 12'h004 && bank_sel
    |=> $stable(clk_minute)) else $error("alarm write reached clock minute");
  hour_read_a: assert property (rd && paddr == 12'h008 && !bank_sel
    |-> prdata == {26'h0, clk_hour}) else $error("hour read wrong");
  pm_flag_a: assert property (!twelve_24_select
    |-> hour_pm == clk_hour[5]) else $error("afternoon flag wrong");
  wday_read_a: assert property (rd && paddr == 12'h00c
    |-> prdata[31:3] == 29'h0) else $error("weekday upper bits set");
  mday_read_a: assert property (rd && paddr == 12'h010
    |-> prdata[31:6] == 26'h0) else $error("day upper bits set");
  fmt_wr_a: assert property (wr && paddr == 12'h014 && bank_sel
    |=> twelve_24_select == $past(pwdata[0])) else $error("format bit not stored");
  bank_wr_a: assert property (wr && paddr == 12'h01c
    |=> bank_sel == $past(pwdata[0])) else $error("bank bit not stored");
endmodule : rtf_monitor
bind rtf_time_date_fields rtf_monitor rtf_monitor_i (.*);

// File: rtf_pkg.sv
// Types shared by the time and date field block.
// Assumes nothing beyond a SystemVerilog compiler.
package rtf_pkg;
  // Register bank selected by the bank control bit.
  typedef enum logic [0:0] {
    RTF_CLOCK_BANK = 1'b0,
    RTF_ALARM_BANK = 1'b1
  } rtf_bank_e;
endpackage : rtf_pkg

// File: rtf_time_date_fields.sv
// Minute, hour, weekday and day-of-month fields of a real-time clock, in a clock bank
// and an alarm bank, reached over APB. Assumes a 20 MHz clk and a master that keeps
// the APB protocol; counting, carry and alarm matching live outside this block.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "rtf_defines.svh"
module rtf_time_date_fields (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [6:0] clk_minute,
  output logic [5:0] clk_hour,
  output logic [2:0] clk_weekday,
  output logic [5:0] clk_mday,
  output logic [6:0] alm_minute,
  output logic [5:0] alm_hour,
  output logic [2:0] alm_weekday,
  output logic [5:0] alm_mday,
  output logic twelve_24_select,
  output logic hour_pm,
  output logic bank_sel
);
  // Per-register address hits; the offsets are distinct, so at most one is set.
  logic hit_min;
  logic hit_hour;
  logic hit_wday;
  logic hit_mday;
  logic hit_month;
  logic hit_bank;
  logic hit;
  // Bus strobes and the bank index that steers banked accesses.
  logic wr_go;
  logic rd_go;
  logic bidx;
  // Field storage; index 0 is the clock bank and index 1 the alarm bank.
  logic [`RTF_MIN_W-1:0] min_q [0:1];
  logic [`RTF_HOUR_W-1:0] hour_q [0:1];
  logic [`RTF_WDAY_W-1:0] wday_q [0:1];
  logic [`RTF_MDAY_W-1:0] mday_q [0:1];
  // Per-bank write enables of the field registers.
  logic [1:0] min_we;
  logic [1:0] hour_we;
  logic [1:0] wday_we;
  logic [1:0] mday_we;
  // Format bit, bank bit and read data.
  logic fmt_we;
  logic fmt_q;
  rtf_pkg::rtf_bank_e bank_r;
  rtf_pkg::rtf_bank_e bank_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Every access completes in its first access cycle, so pready is tied by design.
  assign pready = 1'h1;
  assign wr_go = psel & penable & pwrite & pstrb[0];
  assign rd_go = psel & ~penable & ~pwrite;
  assign bidx = bank_r;

  // Address decode into one hit per register.
  always_comb begin
    hit_min = 1'h0;
    hit_hour = 1'h0;
    hit_wday = 1'h0;
    hit_mday = 1'h0;
    hit_month = 1'h0;
    hit_bank = 1'h0;
    if (paddr == `RTF_OFF_MIN) begin
      hit_min = 1'h1;
    end else if (paddr == `RTF_OFF_HOUR) begin
      hit_hour = 1'h1;
    end else if (paddr == `RTF_OFF_WDAY) begin
      hit_wday = 1'h1;
    end else if (paddr == `RTF_OFF_MDAY) begin
      hit_mday = 1'h1;
    end else if (paddr == `RTF_OFF_MONTH) begin
      hit_month = 1'h1;
    end else if (paddr == `RTF_OFF_BANK) begin
      hit_bank = 1'h1;
    end
  end

  // Unmapped addresses answer with pslverr and change nothing.
  assign hit = hit_min | hit_hour | hit_wday | hit_mday | hit_month | hit_bank;
  assign pslverr = psel & penable & ~hit;

  // Write enables; the selected bank picks which copy of a field is written.
  always_comb begin
    min_we = 2'h0;
    hour_we = 2'h0;
    wday_we = 2'h0;
    mday_we = 2'h0;
    fmt_we = 1'h0;
    if (wr_go) begin
      if (hit_min) begin
        min_we[bidx] = 1'h1;
      end else if (hit_hour) begin
        hour_we[bidx] = 1'h1;
      end else if (hit_wday) begin
        wday_we[bidx] = 1'h1;
      end else if (hit_mday) begin
        mday_we[bidx] = 1'h1;
      end else if (hit_month) begin
        // The format bit exists only in the alarm bank; clock-bank month is outside.
        fmt_we = (bank_r == rtf_pkg::RTF_ALARM_BANK);
      end
    end
  end

  // Bank select next value.
  always_comb begin
    bank_nxt = bank_r;
    if (wr_go && hit_bank) begin
      bank_nxt = rtf_pkg::rtf_bank_e'(pwdata[0]);
    end
  end

  // Read mux; the word is captured in the setup cycle so prdata comes from a flop.
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_go) begin
      rdata_nxt = 32'h0000_0000;
      if (hit_min) begin
        rdata_nxt[`RTF_MIN_W-1:0] = min_q[bidx];
      end else if (hit_hour) begin
        rdata_nxt[`RTF_HOUR_W-1:0] = hour_q[bidx];
      end else if (hit_wday) begin
        rdata_nxt[`RTF_WDAY_W-1:0] = wday_q[bidx];
      end else if (hit_mday) begin
        rdata_nxt[`RTF_MDAY_W-1:0] = mday_q[bidx];
      end else if (hit_month) begin
        if (bank_r == rtf_pkg::RTF_ALARM_BANK) begin
          rdata_nxt[0] = fmt_q;
        end
      end else if (hit_bank) begin
        rdata_nxt[0] = bank_r;
      end
    end
  end

  // Only the bank bit and read data are reset; field values stay undefined
  // after reset like the real counters, which saves reset wiring.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_r <= rtf_pkg::RTF_CLOCK_BANK;
      rdata_r <= 32'h0000_0000;
    end else begin
      bank_r <= bank_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Clock-bank minute; only the field bits are kept, upper bits drop.
  rtf_field_reg #(
    .W(`RTF_MIN_W)
  ) clk_min_reg_i (
    .clk(clk),
    .wr_en(min_we[0]),
    .wr_val(pwdata[`RTF_MIN_W-1:0]),
    .q(min_q[0])
  );

  // Alarm-bank minute.
  rtf_field_reg #(
    .W(`RTF_MIN_W)
  ) alm_min_reg_i (
    .clk(clk),
    .wr_en(min_we[1]),
    .wr_val(pwdata[`RTF_MIN_W-1:0]),
    .q(min_q[1])
  );

  // Clock-bank hour.
  rtf_field_reg #(
    .W(`RTF_HOUR_W)
  ) clk_hour_reg_i (
    .clk(clk),
    .wr_en(hour_we[0]),
    .wr_val(pwdata[`RTF_HOUR_W-1:0]),
    .q(hour_q[0])
  );

  // Alarm-bank hour.
  rtf_field_reg #(
    .W(`RTF_HOUR_W)
  ) alm_hour_reg_i (
    .clk(clk),
    .wr_en(hour_we[1]),
    .wr_val(pwdata[`RTF_HOUR_W-1:0]),
    .q(hour_q[1])
  );

  // Clock-bank weekday.
  rtf_field_reg #(
    .W(`RTF_WDAY_W)
  ) clk_wday_reg_i (
    .clk(clk),
    .wr_en(wday_we[0]),
    .wr_val(pwdata[`RTF_WDAY_W-1:0]),
    .q(wday_q[0])
  );

  // Alarm-bank weekday.
  rtf_field_reg #(
    .W(`RTF_WDAY_W)
  ) alm_wday_reg_i (
    .clk(clk),
    .wr_en(wday_we[1]),
    .wr_val(pwdata[`RTF_WDAY_W-1:0]),
    .q(wday_q[1])
  );

  // Clock-bank day of month.
  rtf_field_reg #(
    .W(`RTF_MDAY_W)
  ) clk_mday_reg_i (
    .clk(clk),
    .wr_en(mday_we[0]),
    .wr_val(pwdata[`RTF_MDAY_W-1:0]),
    .q(mday_q[0])
  );

  // Alarm-bank day of month; banked as well, so alarms can match a date.
  rtf_field_reg #(
    .W(`RTF_MDAY_W)
  ) alm_mday_reg_i (
    .clk(clk),
    .wr_en(mday_we[1]),
    .wr_val(pwdata[`RTF_MDAY_W-1:0]),
    .q(mday_q[1])
  );

  // Hour format bit; undefined until software sets it, as the fields are.
  rtf_field_reg #(
    .W(1)
  ) fmt_reg_i (
    .clk(clk),
    .wr_en(fmt_we),
    .wr_val(pwdata[0:0]),
    .q(fmt_q)
  );

  // Field values to the counting and alarm logic around this block.
  assign prdata = rdata_r;
  assign clk_minute = min_q[0];
  assign clk_hour = hour_q[0];
  assign clk_weekday = wday_q[0];
  assign clk_mday = mday_q[0];
  assign alm_minute = min_q[1];
  assign alm_hour = hour_q[1];
  assign alm_weekday = wday_q[1];
  assign alm_mday = mday_q[1];
  assign twelve_24_select = fmt_q;
  // In 12-hour mode bit 5 of the clock hour marks the afternoon.
  assign hour_pm = ~fmt_q & hour_q[0][`RTF_PM_BIT];
  assign bank_sel = bank_r;
endmodule : rtf_time_date_fields

// One field register without reset; it keeps its value until a write enable.
// No reset on purpose: the field holds whatever it powered up with until written.
module rtf_field_reg #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_val,
  output logic [W-1:0] q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Next value: the written word on a write, else the held value.
  always_comb begin
    q_nxt = q_r;
    if (wr_en) begin
      q_nxt = wr_val;
    end
  end

  // Storage flops.
  always_ff @(posedge clk) begin
    q_r <= q_nxt;
  end

  // The field value as seen by the bank logic.
  assign q = q_r;
endmodule : rtf_field_reg

// File: tb_top.sv
// Self-checking bench for the time and date field block over APB.
// Assumes the design's hand-over timing; the master still waits for pready.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, hour_pm, twelve_24_select, bank_sel;
  logic er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd2;
  logic [3:0] pstrb;
  logic [6:0] clk_minute, alm_minute;
  logic [5:0] clk_hour, clk_mday, alm_hour, alm_mday;
  logic [2:0] clk_weekday, alm_weekday;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [11:0] ad [4] = '{12'h004, 12'h008, 12'h00c, 12'h010};
  logic [7:0] cv [4] = '{8'h59, 8'h23, 8'h06, 8'h31};
  logic [7:0] av [4] = '{8'h00, 8'h31, 8'h00, 8'h01};
  rtf_time_date_fields rtf_time_date_fields_i (.*);
  // Free-running 20 MHz clock.
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // One APB transfer; waiting for the falling edge lets the ending edge's updates settle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clk);
  endtask : apb
  task close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // A hang is cut off well beyond the hundred or so cycles the tests need.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (20) @(posedge clk);
    `CHK(bank_sel, 1'h0)
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) apb(1'h1, ad[i], {24'hffffff, cv[i] | 8'hc0}, 4'hf);
    apb(1'h1, 12'h01c, 32'h1, 4'hf);
    for (int i = 0; i < 4; i++) apb(1'h1, ad[i], {24'h0, av[i]}, 4'hf);
    apb(1'h1, 12'h014, 32'h0, 4'hf);
    `CHK(hour_pm, 1'h1)
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, ad[i], 32'h0, 4'h0);
      `CHK(rd, {24'h0, av[i]})
    end
    $display("test alarm bank done");
    apb(1'h1, 12'h014, 32'hff, 4'hf);
    `CHK(hour_pm, 1'h0)
    apb(1'h0, 12'h014, 32'h0, 4'h0);
    `CHK(rd, 32'h1)
    apb(1'h1, 12'h01c, 32'h0, 4'he);
    `CHK(bank_sel, 1'h1)
    apb(1'h0, 12'h0f0, 32'h0, 4'h0);
    `CHK(er, 1'h1)
    $display("test format and refusal done");
    apb(1'h1, 12'h01c, 32'h0, 4'hf);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, ad[i], 32'h0, 4'h0);
      `CHK(rd, {24'h0, cv[i]})
      rd2 = rd;
      apb(1'h0, ad[i], 32'h0, 4'h0);
      `CHK(rd, rd2)
    end
    `CHK(alm_hour, 6'h31)
    `CHK(alm_minute, 7'h00)
    `CHK(alm_weekday, 3'h0)
    `CHK(alm_mday, 6'h01)
    `CHK(clk_minute, 7'h59)
    `CHK(clk_hour, 6'h23)
    `CHK(clk_weekday, 3'h6)
    `CHK(clk_mday, 6'h31)
    `CHK(twelve_24_select, 1'h1)
    $display("test clock bank done");
    close_out();
  end
endmodule : tb_top
